/* File: verilog/fdm_map.svh */
// Purpose: Register offsets, field positions, reset values and limits
//          of the format description mode page block.
// Assumes: 32-bit APB, each register one aligned word.
// Notes:   Page words are the page bytes packed four per word, MSB first.
`ifndef FDM_MAP_SVH
`define FDM_MAP_SVH

`define FDM_OFF_W0        12'h000
`define FDM_OFF_W1        12'h004
`define FDM_OFF_W2        12'h008
`define FDM_OFF_W3        12'h00c
`define FDM_OFF_W4        12'h010
`define FDM_OFF_W5        12'h014
`define FDM_OFF_CMD       12'h018
`define FDM_OFF_STATUS    12'h01c
`define FDM_OFF_CFG       12'h020
`define FDM_OFF_CAP       12'h024
`define FDM_OFF_EFF0      12'h028
`define FDM_OFF_EFF1      12'h02c
`define FDM_OFF_EFF2      12'h030

`define FDM_PAGE_CODE     6'h03
`define FDM_PAGE_LEN      8'h16

`define FDM_CMD_APPLY     0
`define FDM_CMD_FMT_DONE  1
`define FDM_STS_W1C_CHECK 0

`define FDM_DFLT_TPZ      16'h0000
`define FDM_DFLT_ASZ      16'h0002
`define FDM_DFLT_ATZ      16'h0001
`define FDM_DFLT_ATL      16'h0004
`define FDM_DFLT_SPT      16'h0040
`define FDM_DFLT_BPS      16'h0200
`define FDM_MAX_TPZ       16'h1000
`define FDM_MAX_ASZ       16'h0040
`define FDM_MAX_ATZ       16'h0008
`define FDM_MAX_ATL       16'h0100
`define FDM_MAX_SPT       16'h0400
`define FDM_MAX_BPS       16'h1000

`define FDM_RST_CAP       32'h0002_0000
`define FDM_RST_ILV       16'h0001

`endif

/* File: verilog/fdm_pkg.sv */
// Purpose: Types shared by the format description mode page block.
// Assumes: Constants live in fdm_map.svh.
// Notes:   Config and status structs are laid out to match their register words bit for bit.
package fdm_pkg;

  typedef struct packed {
    logic [15:0] active_notch;
    logic [11:0] reserved;
    logic        variable_spt;
    logic        notched_unit_flag;
    logic        notch_page_present;
    logic        nv_save_capable;
  } fdm_cfg_type;

  typedef struct packed {
    logic [28:0] reserved;
    logic        rounded;
    logic        format_pending;
    logic        check_condition;
  } fdm_status_type;

  typedef struct packed {
    logic [15:0] bytes_per_sector;
    logic [15:0] sectors_per_track;
    logic [15:0] alt_tracks_per_lu;
    logic [15:0] alt_tracks_per_zone;
    logic [15:0] alt_sectors_per_zone;
    logic [15:0] tracks_per_zone;
  } fdm_alloc_type;

endpackage : fdm_pkg

/* File: verilog/fdm_field_resolve.sv */
// Purpose: Rounds one requested two-byte page field and resolves zero.
// Assumes: Purely combinational, used once per allocation field.
// Notes:   kept is what sense returns, except sectors per track when variable_spt is set; eff is what the target uses.
`timescale 1ns/1ps
module fdm_field_resolve #(
  parameter logic [15:0] DFLT      = 16'h0000,
  parameter logic [15:0] MAXV      = 16'hffff,
  parameter bit          ZERO_KEEP = 1'b0
) (
  input  wire logic [15:0] req,
  input  wire logic        zero_none,
  output logic      [15:0] kept,
  output logic      [15:0] eff,
  output logic             rounded
);

  wire zero_req = (req == 16'h0000);

  // Over-large requests are clamped rather than refused
  assign rounded = (req > MAXV);
  assign kept    = rounded ? MAXV : req;
  // Zero: whole span, none, or the target's own count
  assign eff     = !zero_req ? kept :
                   (ZERO_KEEP || zero_none) ? 16'h0000 : DFLT;

endmodule : fdm_field_resolve

/* File: verilog/fdm_mode_page.sv */
// Purpose: Target side of the format description mode page over APB.
// Assumes: Firmware stages mode select data in the page words, then
//          issues apply; reads of the page words return sense data.
// Notes:   Zero wait states; unmapped addresses answer with pslverr.
`timescale 1ns/1ps
`include "fdm_map.svh"

module fdm_mode_page
  import fdm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             medium_access_ok,
  output logic             check_condition
);

  localparam logic [15:0] DF_TAB [6] = '{`FDM_DFLT_TPZ, `FDM_DFLT_ASZ,
    `FDM_DFLT_ATZ, `FDM_DFLT_ATL, `FDM_DFLT_SPT, `FDM_DFLT_BPS};
  localparam logic [15:0] MX_TAB [6] = '{`FDM_MAX_TPZ, `FDM_MAX_ASZ,
    `FDM_MAX_ATZ, `FDM_MAX_ATL, `FDM_MAX_SPT, `FDM_MAX_BPS};

  fdm_alloc_type  stg_q;
  fdm_alloc_type  cur_q;
  fdm_alloc_type  eff_q;
  fdm_alloc_type  kept;
  fdm_alloc_type  eff;
  fdm_cfg_type    cfg_q;
  fdm_status_type sts;
  logic           chk_q;
  logic           pend_q;
  logic           rnd_q;
  logic [5:0]     stg_code_q;
  logic [15:0]    stg_skew_q;
  logic [15:0]    skew_q;
  logic [15:0]    ilv_q;
  logic [31:0]    cap_q;
  logic [5:0]     rnd_vec;

  // Bus decode
  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire hit_w0   = (paddr == `FDM_OFF_W0);
  wire hit_w1   = (paddr == `FDM_OFF_W1);
  wire hit_w2   = (paddr == `FDM_OFF_W2);
  wire hit_w3   = (paddr == `FDM_OFF_W3);
  wire hit_w4   = (paddr == `FDM_OFF_W4);
  wire hit_w5   = (paddr == `FDM_OFF_W5);
  wire hit_cmd  = (paddr == `FDM_OFF_CMD);
  wire hit_sts  = (paddr == `FDM_OFF_STATUS);
  wire hit_cfg  = (paddr == `FDM_OFF_CFG);
  wire hit_cap  = (paddr == `FDM_OFF_CAP);
  wire hit_e0   = (paddr == `FDM_OFF_EFF0);
  wire hit_e1   = (paddr == `FDM_OFF_EFF1);
  wire hit_e2   = (paddr == `FDM_OFF_EFF2);
  wire mapped   = hit_w0 | hit_w1 | hit_w2 | hit_w3 | hit_w4 | hit_w5 |
                  hit_cmd | hit_sts | hit_cfg | hit_cap | hit_e0 |
                  hit_e1 | hit_e2;

  wire cmd_apply = wr && hit_cmd && pwdata[`FDM_CMD_APPLY];
  wire cmd_fmt   = wr && hit_cmd && pwdata[`FDM_CMD_FMT_DONE];

  wire zero_none = cfg_q.notch_page_present && cfg_q.notched_unit_flag &&
                   (cfg_q.active_notch == 16'h0000);

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_res
      fdm_field_resolve #(
        .DFLT      (DF_TAB[gi]),
        .MAXV      (MX_TAB[gi]),
        .ZERO_KEEP (gi == 0)
      ) i_fdm_field_resolve (
        .req       (stg_q[16*gi +: 16]),
        .zero_none (zero_none && (gi >= 1) && (gi <= 3)),
        .kept      (kept[16*gi +: 16]),
        .eff       (eff[16*gi +: 16]),
        .rounded   (rnd_vec[gi])
      );
    end
  endgenerate

  // Resolved sizes are checked, so zero fields count too
  // capacity of one track
  wire [31:0] track_bytes = eff.sectors_per_track * eff.bytes_per_sector;
  wire        cap_bad     = (track_bytes > cap_q);
  // select data must carry this page
  wire        code_bad    = (stg_code_q != `FDM_PAGE_CODE);
  wire        var_bad     = cfg_q.variable_spt &&
                            (stg_q.sectors_per_track != 16'h0000);
  wire        sel_fail    = cap_bad || code_bad || var_bad;
  wire        sel_ok      = cmd_apply && !sel_fail;
  // physical change needs a new format
  wire        phys_chg    = (kept != cur_q) || (stg_skew_q != skew_q);

  wire [15:0] spt_sense   = cfg_q.variable_spt ? eff_q.sectors_per_track
                                               : cur_q.sectors_per_track;

  wire [31:0] rd_w0  = {cfg_q.nv_save_capable, 1'b0, `FDM_PAGE_CODE,
                        `FDM_PAGE_LEN, cur_q.tracks_per_zone};
  wire [31:0] rd_w1  = {cur_q.alt_sectors_per_zone,
                        cur_q.alt_tracks_per_zone};
  wire [31:0] rd_w2  = {cur_q.alt_tracks_per_lu, spt_sense};
  wire [31:0] rd_w3  = {cur_q.bytes_per_sector, ilv_q};
  wire [31:0] rd_w4  = {skew_q, 16'h0000};
  wire [31:0] rd_cfg = cfg_q.notched_unit_flag ? cfg_q :
                       {16'h0000, 12'h000, cfg_q.variable_spt, 1'b0,
                        cfg_q.notch_page_present, cfg_q.nv_save_capable};
  wire [31:0] rd_e0  = {eff_q.alt_sectors_per_zone,
                        eff_q.alt_tracks_per_zone};
  wire [31:0] rd_e1  = {eff_q.alt_tracks_per_lu, eff_q.sectors_per_track};
  wire [31:0] rd_e2  = {eff_q.bytes_per_sector, eff_q.tracks_per_zone};

  wire [31:0] rd_mux = hit_w0  ? rd_w0 :
                       hit_w1  ? rd_w1 :
                       hit_w2  ? rd_w2 :
                       hit_w3  ? rd_w3 :
                       hit_w4  ? rd_w4 :
                       hit_sts ? sts :
                       hit_cfg ? rd_cfg :
                       hit_cap ? cap_q :
                       hit_e0  ? rd_e0 :
                       hit_e1  ? rd_e1 :
                       hit_e2  ? rd_e2 : 32'h0000_0000;

  // Read data registered during setup so it is stable in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // No wait states: every access completes in its first cycle
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // Staging of mode select data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stg_q      <= '0;
      stg_code_q <= `FDM_PAGE_CODE;
      stg_skew_q <= 16'h0000;
    end else if (wr) begin
      if (hit_w0) begin
        stg_code_q            <= pwdata[29:24];
        stg_q.tracks_per_zone <= pwdata[15:0];
      end
      if (hit_w1) begin
        stg_q.alt_sectors_per_zone <= pwdata[31:16];
        stg_q.alt_tracks_per_zone  <= pwdata[15:0];
      end
      if (hit_w2) begin
        stg_q.alt_tracks_per_lu <= pwdata[31:16];
        stg_q.sectors_per_track <= pwdata[15:0];
      end
      if (hit_w3) begin
        stg_q.bytes_per_sector <= pwdata[31:16];
      end
      if (hit_w4) begin
        stg_skew_q <= pwdata[31:16];
      end
    end
  end

  // Current page and effective values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q  <= '0;
      eff_q  <= '0;
      skew_q <= 16'h0000;
    end else if (sel_ok) begin
      cur_q  <= kept;
      eff_q  <= eff;
      skew_q <= stg_skew_q;
    end
  end

  // Interleave comes only from a completed format
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ilv_q <= `FDM_RST_ILV;
    end else if (cmd_fmt) begin
      ilv_q <= pwdata[31:16];
    end
  end

  // Configuration and capacity registers
  wire cfg_wr = wr && hit_cfg;
  wire cap_wr = wr && hit_cap;

  // Reserved configuration bits are forced to zero on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
    end else if (cfg_wr) begin
      cfg_q          <= pwdata;
      cfg_q.reserved <= 12'h000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q <= `FDM_RST_CAP;
    end else if (cap_wr) begin
      cap_q <= pwdata;
    end
  end

  // Status: every set beats a same-cycle clear
  wire chk_clr  = wr && hit_sts && pwdata[`FDM_STS_W1C_CHECK];
  // A failed apply only raises check; the page is left untouched
  // sticky check condition
  wire chk_set  = cmd_apply && sel_fail;
  wire chk_d    = chk_set || (chk_q && !(chk_clr || sel_ok));
  // Apply and format done in one write leave pending set if the apply changes the format
  // lock medium until format
  wire pend_set = sel_ok && phys_chg;
  wire pend_d   = pend_set || (pend_q && !cmd_fmt);
  wire rnd_d    = sel_ok ? (|rnd_vec) : rnd_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_q <= 1'b0;
    end else begin
      chk_q <= chk_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rnd_q <= 1'b0;
    end else begin
      rnd_q <= rnd_d;
    end
  end

  assign sts              = {29'h0, rnd_q, pend_q, chk_q};
  assign medium_access_ok = !pend_q;
  assign check_condition  = chk_q;

endmodule : fdm_mode_page

/* File: tb/fdm_mode_page_properties.sv */
// Purpose: Port-level checks of the format description mode page block.
// Assumes: Word aligned APB addresses only.
// Notes:   Checks flags against the APB writes that move them.
`timescale 1ns/1ps
module fdm_mode_page_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        medium_access_ok,
  input wire logic        check_condition
);
  wire acc_rd = psel && penable && !pwrite;
  wire acc_wr = psel && penable && pwrite;
  wire ap_w   = acc_wr && paddr == 12'h018 && pwdata[0];
  wire w1c_w  = acc_wr && paddr == 12'h01c && pwdata[0];
  wire clr_w  = ap_w || w1c_w;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_apply;
    ap_w;
  endsequence
  sequence s_done;
    acc_wr && paddr == 12'h018 && pwdata[1] && !pwdata[0];
  endsequence

  ready_always_a: assert property (psel && penable |-> pready)
    else $error("access without ready");
  unmapped_err_a: assert property (
    psel && penable |-> pslverr == (paddr > 12'h030))
    else $error("slave error on wrong address");
  page_code_a: assert property (
    acc_rd && paddr == 12'h000 |-> prdata[30:16] == 15'h0316)
    else $error("page code or length wrong");
  w5_zero_a: assert property (
    acc_rd && (paddr == 12'h014 || paddr == 12'h018) |-> prdata == 32'h0)
    else $error("reserved word not zero");
  status_resv_a: assert property (
    acc_rd && paddr == 12'h01c |->
      prdata[31:3] == 29'h0 && prdata[0] == check_condition)
    else $error("status word wrong");
  fmt_done_a: assert property (s_done |=> medium_access_ok)
    else $error("medium still blocked after format");
  access_drop_a: assert property (
    $fell(medium_access_ok) |-> $past(ap_w))
    else $error("medium blocked without apply");
  check_rise_a: assert property (
    $rose(check_condition) |-> $past(ap_w))
    else $error("check raised without apply");
  check_fall_a: assert property (
    $fell(check_condition) |-> $past(clr_w))
    else $error("check dropped on its own");
  w1c_clear_a: assert property (w1c_w |=> !check_condition)
    else $error("check not cleared");
  apply_seen_c: cover property (s_apply);
endmodule : fdm_mode_page_properties

bind fdm_mode_page fdm_mode_page_properties i_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .medium_access_ok, .check_condition);

/* File: tb/fdm_host.sv */
// Purpose: Initiator model issuing mode select and sense traffic on APB.
// Assumes: Called just after a clock edge; waits for pready.
// Notes:   Released address and data show inverted last values.
`timescale 1ns/1ps
module fdm_host (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : fdm_host

/* File: tb/fdm_mode_page_bench.sv */
// Purpose: Self-checking bench of the format description mode page.
// Assumes: Expected words follow the register map and defaults.
// Notes:   Flags are sampled one cycle after the write edge.
`timescale 1ns/1ps
module fdm_mode_page_bench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        medium_access_ok;
  logic        check_condition;
  logic        last_err;
  int          num_errors;
  int          num_checks;

  fdm_mode_page i_fdm_mode_page (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .medium_access_ok, .check_condition);
  fdm_host i_fdm_host (
    .pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr,
    .pwdata);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_fdm_host.xfer(1'b1, a, d, q, last_err);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_fdm_host.xfer(1'b0, a, 32'h0, q, last_err);
    cmp(q, exp);
  endtask : rd

  task automatic flags(input logic m, input logic c);
    @(posedge pclk);
    #1;
    cmp({30'h0, medium_access_ok, check_condition}, {30'h0, m, c});
  endtask : flags

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // Whole run is a few hundred cycles
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  initial begin
    num_errors = 0;
    num_checks = 0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h0, 32'h0316_0000);
    rd(12'hc, 32'h1);
    flags(1'b1, 1'b0);
    $display("test reset done");
    wr(12'h20, 32'h1);
    rd(12'h0, 32'h8316_0000);
    wr(12'h0, 32'h8300_0010);
    wr(12'h20, 32'h0);
    wr(12'h18, 32'h1);
    rd(12'h0, 32'h0316_0010);
    wr(12'h18, 32'h1_0002);
    $display("test savable done");
    wr(12'h4, 32'h5_0003);
    wr(12'h8, 32'h10_0020);
    wr(12'hc, 32'h100_7777);
    wr(12'h10, 32'h7_1234);
    wr(12'h18, 32'h1);
    flags(1'b0, 1'b0);
    rd(12'h4, 32'h5_0003);
    rd(12'h8, 32'h10_0020);
    rd(12'hc, 32'h100_0001);
    rd(12'h10, 32'h7_0000);
    rd(12'h28, 32'h5_0003);
    rd(12'h30, 32'h100_0010);
    rd(12'h1c, 32'h2);
    wr(12'h18, 32'h3_0002);
    flags(1'b1, 1'b0);
    wr(12'hc, 32'h100_0003);
    rd(12'hc, 32'h100_0003);
    wr(12'h4, 32'h100_0020);
    wr(12'h18, 32'h1);
    rd(12'h4, 32'h40_0008);
    rd(12'h1c, 32'h6);
    $display("test apply done");
    wr(12'h4, 32'h0);
    wr(12'h8, 32'h0);
    wr(12'hc, 32'h0);
    wr(12'h18, 32'h1);
    rd(12'h28, 32'h2_0001);
    rd(12'h2c, 32'h4_0040);
    rd(12'h30, 32'h200_0010);
    wr(12'h20, 32'h6);
    wr(12'h18, 32'h1);
    rd(12'h28, 32'h0);
    rd(12'h2c, 32'h40);
    wr(12'h20, 32'h1_0006);
    wr(12'h18, 32'h1);
    rd(12'h28, 32'h2_0001);
    wr(12'h20, 32'h5_0002);
    rd(12'h20, 32'h2);
    wr(12'h18, 32'h3_0002);
    $display("test zero done");
    wr(12'h8, 32'h400);
    wr(12'hc, 32'h1000_0000);
    wr(12'h18, 32'h1);
    flags(1'b1, 1'b1);
    rd(12'h8, 32'h0);
    wr(12'h1c, 32'h1);
    flags(1'b1, 1'b0);
    wr(12'h8, 32'h200);
    wr(12'hc, 32'h100_0000);
    wr(12'h18, 32'h1);
    flags(1'b0, 1'b0);
    wr(12'h18, 32'h3_0002);
    wr(12'h0, 32'h0400_0000);
    wr(12'h18, 32'h1);
    flags(1'b1, 1'b1);
    wr(12'h0, 32'h0300_0010);
    wr(12'h1c, 32'h1);
    wr(12'h20, 32'h8);
    wr(12'h8, 32'h10);
    wr(12'h18, 32'h1);
    flags(1'b1, 1'b1);
    wr(12'h1c, 32'h1);
    wr(12'h8, 32'h0);
    wr(12'h18, 32'h1);
    rd(12'h8, 32'h40);
    wr(12'h10, 32'h9_0000);
    wr(12'h18, 32'h5_0003);
    flags(1'b0, 1'b0);
    rd(12'hc, 32'h100_0005);
    // Initiator sets at most one sector formatting flag
    wr(12'h14, 32'h8000_0000);
    rd(12'h14, 32'h0);
    rd(12'h40, 32'h0);
    cmp({31'h0, last_err}, 32'h1);
    $display("test limits done");
    stop_test();
  end
endmodule : fdm_mode_page_bench
